// File: rtl/apuhb_top.sv
// Host bus interface of the stack arithmetic unit
//
// Overview of operation
// - Reset aborts command, clears status, resets pointer
// - After reset done high, attention low
// - Select and strobes decode push, pop, command, status
// - Done low at completion, cleared by ack/access
// - Done flop set at completion even during ack; ack then clears it
// - Status readable while busy; avoid continuous polling
// - Attention rises only when service bit set
// - Attention drops on ack, reset, or plain completion
// - Eight-bit active-high bus, bit 0 least significant
// - Pops return most significant byte first
// - Byte count per format: two or four
// - Strobes ignored unless unit select low
// - Write starts at strobe fall, hold brief unless command while busy or push into full buffer
// - Read holds until data valid, then drives
// - Read strobe fall clears done
// - Strobes may be asynchronous to clock
// - Done signalled after every completed command
// - Command: op bits 0-4, format 5-6, service bit 7
// - Write strobe rise clears done
`default_nettype none
`include "apuhb_defs.svh"
module apuhb_top (
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    input wire logic i_reset,
    input wire logic i_unit_select_n,
    input wire logic i_cmd_data_sel,
    input wire logic i_read_strobe_n,
    input wire logic i_store_strobe_n,
    input wire logic [7:0] i_host_bus,
    output logic [7:0] o_host_bus,
    output logic o_host_bus_oe,
    output logic o_xfer_hold_n,
    output logic o_exec_done_n_oe,
    output logic o_host_attention,
    input wire logic i_done_ack_n,
    input wire logic i_attention_ack_n,
    output logic o_cmd_valid,
    input wire logic i_cmd_ready,
    output logic [4:0] o_cmd_op,
    output logic [1:0] o_cmd_fmt,
    input wire logic i_cmd_complete,
    input wire logic [7:0] i_status,
    output logic o_push_valid,
    input wire logic i_push_ready,
    output logic [7:0] o_push_data,
    output logic o_pop_req,
    output logic [`APUHB_SP_W-1:0] o_pop_index,
    input wire logic [7:0] i_pop_data,
    output logic [`APUHB_SP_W-1:0] o_stack_ptr,
    output logic o_busy
);
    ////////////////////////////////////////////////////////////////////////
    // Input synchronisation

    logic [5:0] pin_sync;
    logic sel_n_s;
    logic cd_s;
    logic rd_n_s;
    logic wr_n_s;
    logic rst_s;
    logic dack_n_s;
    logic aack_n_s;
    logic rd_n_d_ff;
    logic wr_n_d_ff;

    // Strobes, select and acks pass four flops
    apuhb_sync #(.W(6), .RST_VAL(6'h3f)) u_sync (
        .i_clk_sys(i_clk_sys),
        .i_nrst(i_nrst),
        .i_async({i_unit_select_n, i_cmd_data_sel, i_read_strobe_n, i_store_strobe_n,
                  i_done_ack_n, i_attention_ack_n}),
        .o_sync(pin_sync)
    );
    assign sel_n_s = pin_sync[5];
    assign cd_s = pin_sync[4];
    assign rd_n_s = pin_sync[3];
    assign wr_n_s = pin_sync[2];
    assign dack_n_s = pin_sync[1];
    assign aack_n_s = pin_sync[0];

    apuhb_sync #(.W(1), .RST_VAL(1'b1)) u_rsync (
        .i_clk_sys(i_clk_sys),
        .i_nrst(i_nrst),
        .i_async(i_reset),
        .o_sync(rst_s)
    );

    // Previous strobe levels for edge detection
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            rd_n_d_ff <= 1'b1;
            wr_n_d_ff <= 1'b1;
        end else begin
            rd_n_d_ff <= rd_n_s;
            wr_n_d_ff <= wr_n_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Access decode

    logic rd_fall;
    logic wr_fall;
    logic wr_rise;
    apuhb_pkg::apuhb_xfer_t xfer;

    // Strobes count only with select low and never both
    assign rd_fall = rd_n_d_ff && !rd_n_s && !sel_n_s && wr_n_s;
    assign wr_fall = wr_n_d_ff && !wr_n_s && !sel_n_s && rd_n_s;
    assign wr_rise = !wr_n_d_ff && wr_n_s && !sel_n_s;

    // Transfer type from select line and strobe
    function automatic apuhb_pkg::apuhb_xfer_t decode_xfer(input logic cd, input logic is_rd);
        decode_xfer = cd ? (is_rd ? apuhb_pkg::XF_STAT : apuhb_pkg::XF_CMD)
                         : (is_rd ? apuhb_pkg::XF_POP : apuhb_pkg::XF_PUSH);
    endfunction

    assign xfer = decode_xfer(cd_s, !rd_n_s);

    ////////////////////////////////////////////////////////////////////////
    // Bus handshake state machine

    apuhb_pkg::apuhb_state_t state_ff;
    apuhb_pkg::apuhb_state_t nxt_state;
    logic [7:0] wr_data_ff;
    logic [7:0] rd_data_ff;
    logic [7:0] cmd_ff;
    logic [`APUHB_SP_W-1:0] sp_ff;
    logic busy_ff;
    logic cmd_load;
    logic push_take;
    logic push_in_ready;
    logic fifo_valid;
    logic [7:0] fifo_data;

    // Sequencing of write and read holds
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            apuhb_pkg::ST_IDLE: begin
                if (wr_fall) begin
                    nxt_state = apuhb_pkg::ST_WR_HOLD;
                end else if (rd_fall) begin
                    nxt_state = apuhb_pkg::ST_RD_FETCH;
                end
            end
            apuhb_pkg::ST_WR_HOLD: begin
                if (xfer == apuhb_pkg::XF_CMD ? !busy_ff : push_in_ready) begin
                    nxt_state = apuhb_pkg::ST_WR_WAIT;
                end
            end
            apuhb_pkg::ST_WR_WAIT: begin
                if (wr_n_s) begin
                    nxt_state = apuhb_pkg::ST_IDLE;
                end
            end
            apuhb_pkg::ST_RD_FETCH: begin
                nxt_state = apuhb_pkg::ST_RD_DRIVE;
            end
            apuhb_pkg::ST_RD_DRIVE: begin
                if (rd_n_s) begin
                    nxt_state = apuhb_pkg::ST_IDLE;
                end
            end
            default: begin
                nxt_state = apuhb_pkg::ST_IDLE;
            end
        endcase
    end

    // State register; external reset aborts transfer
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            state_ff <= apuhb_pkg::ST_IDLE;
        end else if (rst_s) begin
            state_ff <= apuhb_pkg::ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Hold low from strobe fall until the transfer is done
    assign o_xfer_hold_n = !(state_ff == apuhb_pkg::ST_WR_HOLD
                             || state_ff == apuhb_pkg::ST_RD_FETCH
                             || (state_ff == apuhb_pkg::ST_IDLE && (wr_fall || rd_fall)));

    // Latch write data at strobe fall; bus bit 0 is LSB
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            wr_data_ff <= 8'h00;
        end else if (wr_fall && state_ff == apuhb_pkg::ST_IDLE) begin
            wr_data_ff <= i_host_bus;
        end
    end

    assign cmd_load = state_ff == apuhb_pkg::ST_WR_HOLD && xfer == apuhb_pkg::XF_CMD
                      && !busy_ff;
    assign push_take = state_ff == apuhb_pkg::ST_WR_HOLD && xfer == apuhb_pkg::XF_PUSH
                       && push_in_ready;

    // Command register survives external reset
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            cmd_ff <= `APUHB_CMD_RST;
        end else if (cmd_load) begin
            cmd_ff <= wr_data_ff;
        end
    end

    // Busy from command entry to completion; reset aborts
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            busy_ff <= 1'b0;
        end else if (rst_s) begin
            busy_ff <= 1'b0;
        end else if (cmd_load) begin
            busy_ff <= 1'b1;
        end else if (i_cmd_complete) begin
            busy_ff <= 1'b0;
        end
    end

    // Byte pointer: push up, pop down; reset reinitialises
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            sp_ff <= '0;
        end else if (rst_s) begin
            sp_ff <= '0;
        end else if (push_take) begin
            sp_ff <= `APUHB_SP_W'(sp_ff + 1'b1);
        end else if (state_ff == apuhb_pkg::ST_RD_FETCH && xfer == apuhb_pkg::XF_POP) begin
            sp_ff <= `APUHB_SP_W'(sp_ff - 1'b1);
        end
    end

    // Read data: pops return last pushed, MSB first
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            rd_data_ff <= 8'h00;
        end else if (rst_s) begin
            rd_data_ff <= `APUHB_STATUS_RST;
        end else if (state_ff == apuhb_pkg::ST_RD_FETCH) begin
            rd_data_ff <= (xfer == apuhb_pkg::XF_STAT) ? {busy_ff, i_status[6:0]} : i_pop_data;
        end
    end

    // Drive bus while read strobe stays low
    assign o_host_bus = rd_data_ff;
    assign o_host_bus_oe = state_ff == apuhb_pkg::ST_RD_DRIVE && !rd_n_s;

    assign o_pop_req = state_ff == apuhb_pkg::ST_RD_FETCH && xfer == apuhb_pkg::XF_POP;
    assign o_pop_index = `APUHB_SP_W'(sp_ff - 1'b1);
    assign o_stack_ptr = sp_ff;
    assign o_busy = busy_ff;

    // Command fields toward the engine
    assign o_cmd_valid = busy_ff;
    assign o_cmd_op = cmd_ff[`APUHB_CMD_OP_HI:0];
    assign o_cmd_fmt = cmd_ff[`APUHB_CMD_FMT_HI:`APUHB_CMD_FMT_LO];

    ////////////////////////////////////////////////////////////////////////
    // Push data buffer

    // Pushed bytes queue toward the stack; full stalls the hold
    apuhb_fifo #(.WIDTH(8), .DEPTH(`APUHB_FIFO_DEPTH), .AW(`APUHB_FIFO_AW)) u_fifo (
        .i_clk_sys(i_clk_sys),
        .i_nrst(i_nrst),
        .i_flush(rst_s),
        .i_in_valid(push_take),
        .o_in_ready(push_in_ready),
        .i_in_data(wr_data_ff),
        .o_out_valid(fifo_valid),
        .i_out_ready(i_push_ready),
        .o_out_data(fifo_data)
    );
    assign o_push_valid = fifo_valid;
    assign o_push_data = fifo_data;

    ////////////////////////////////////////////////////////////////////////
    // Completion flags

    logic done_ff;
    logic attn_ff;
    logic done_clr;

    // Access clears done: read at fall, write at rise
    assign done_clr = !dack_n_s || rd_fall || wr_rise;

    // Done flop: completion sets and wins over clear
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            done_ff <= 1'b0;
        end else if (rst_s) begin
            done_ff <= 1'b0;
        end else if (i_cmd_complete && busy_ff) begin
            done_ff <= 1'b1;
        end else if (done_clr) begin
            done_ff <= 1'b0;
        end
    end

    // Open drain: pull low while done set; released in reset
    assign o_exec_done_n_oe = done_ff;

    // Attention follows service bit at completion
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            attn_ff <= 1'b0;
        end else if (rst_s) begin
            attn_ff <= 1'b0;
        end else if (i_cmd_complete && busy_ff) begin
            attn_ff <= cmd_ff[`APUHB_CMD_SR_BIT];
        end else if (!aack_n_s) begin
            attn_ff <= 1'b0;
        end
    end

    assign o_host_attention = attn_ff;
endmodule
`default_nettype wire

// File: rtl/apuhb_defs.svh
// Constants for the arithmetic unit host bus interface
`ifndef APUHB_DEFS_SVH
`define APUHB_DEFS_SVH
`define APUHB_SYNC_DEPTH 3
`define APUHB_FIFO_DEPTH 8
`define APUHB_FIFO_AW 3
`define APUHB_DATA_W 8
`define APUHB_CMD_SR_BIT 7
`define APUHB_CMD_FMT_LO 5
`define APUHB_CMD_FMT_HI 6
`define APUHB_CMD_OP_HI 4
`define APUHB_STACK_BYTES 32
`define APUHB_SP_W 5
`define APUHB_STATUS_RST 8'h00
`define APUHB_CMD_RST 8'h00
`define APUHB_HOLD_WR_CYC 2'h1
`endif

// File: rtl/apuhb_pkg.sv
// Types shared by the host bus interface files
`default_nettype none
package apuhb_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_WR_HOLD = 3'b001,
        ST_WR_WAIT = 3'b010,
        ST_RD_FETCH = 3'b011,
        ST_RD_DRIVE = 3'b100
    } apuhb_state_t;
    typedef enum logic [1:0] {
        XF_PUSH = 2'b00,
        XF_POP = 2'b01,
        XF_CMD = 2'b10,
        XF_STAT = 2'b11
    } apuhb_xfer_t;
endpackage
`default_nettype wire

// File: rtl/apuhb_sync.sv
// Three-stage synchroniser for asynchronous pin inputs
`default_nettype none
`include "apuhb_defs.svh"
module apuhb_sync #(
    parameter int W = 4,
    parameter logic [W-1:0] RST_VAL = '1
) (
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    logic [W-1:0] s1_ff;
    logic [W-1:0] s2_ff;
    logic [W-1:0] s3_ff;
    logic [W-1:0] held_ff;

    // Shift chain; first stage feeds only the second
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            s1_ff <= RST_VAL;
            s2_ff <= RST_VAL;
            s3_ff <= RST_VAL;
        end else begin
            s1_ff <= i_async;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    // Accept a bit once stages two and three agree
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            held_ff <= RST_VAL;
        end else begin
            for (int k = 0; k < W; k++) begin
                if (s2_ff[k] == s3_ff[k]) begin
                    held_ff[k] <= s3_ff[k];
                end
            end
        end
    end

    assign o_sync = held_ff;
endmodule
`default_nettype wire

// File: rtl/apuhb_fifo.sv
// Small valid/ready FIFO of flip-flops
`default_nettype none
`include "apuhb_defs.svh"
module apuhb_fifo #(
    parameter int WIDTH = `APUHB_DATA_W,
    parameter int DEPTH = `APUHB_FIFO_DEPTH,
    parameter int AW = `APUHB_FIFO_AW
) (
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    input wire logic i_flush,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wr_ptr_ff;
    logic [AW-1:0] rd_ptr_ff;
    logic [AW:0] count_ff;
    logic do_wr;
    logic do_rd;

    // Handshake terms
    assign o_in_ready = (count_ff != AW'(0) + (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
    assign o_out_valid = (count_ff != '0);
    assign do_wr = i_in_valid && o_in_ready;
    assign do_rd = o_out_valid && i_out_ready;
    assign o_out_data = mem_ff[rd_ptr_ff];

    // Storage
    always_ff @(posedge i_clk_sys) begin
        if (do_wr) begin
            mem_ff[wr_ptr_ff] <= i_in_data;
        end
    end

    // Pointers and fill count
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
        end else if (i_flush) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
        end else begin
            if (do_wr) begin
                wr_ptr_ff <= AW'(wr_ptr_ff + 1'b1);
            end
            if (do_rd) begin
                rd_ptr_ff <= AW'(rd_ptr_ff + 1'b1);
            end
            if (do_wr && !do_rd) begin
                count_ff <= (AW+1)'(count_ff + 1'b1);
            end else if (!do_wr && do_rd) begin
                count_ff <= (AW+1)'(count_ff - 1'b1);
            end
        end
    end
endmodule
`default_nettype wire

// File: testbench/apuhb_checker.sv
// Port checker for the host bus interface
`default_nettype none
module apuhb_checker (
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    input wire logic i_reset,
    input wire logic i_unit_select_n,
    input wire logic i_read_strobe_n,
    input wire logic [7:0] o_host_bus,
    input wire logic o_host_bus_oe,
    input wire logic o_xfer_hold_n,
    input wire logic o_exec_done_n_oe,
    input wire logic o_host_attention,
    input wire logic i_done_ack_n,
    input wire logic i_attention_ack_n,
    input wire logic i_cmd_complete,
    input wire logic o_pop_req,
    input wire logic [4:0] o_pop_index,
    input wire logic [4:0] o_stack_ptr,
    input wire logic o_busy
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_nrst);
    ////////////////////////////////////////////////////////////////
    property p_oe_hold;
        o_host_bus_oe |-> o_xfer_hold_n;
    endproperty
    a_oe_hold: assert property (p_oe_hold) else $error("bus driven while hold low");
    property p_data_stable;
        o_host_bus_oe && $past(o_host_bus_oe) |-> $stable(o_host_bus);
    endproperty
    a_data_stable: assert property (p_data_stable) else $error("read data moved");
    property p_oe_release;
        i_read_strobe_n [*6] |-> !o_host_bus_oe;
    endproperty
    a_oe_release: assert property (p_oe_release) else $error("bus driven without read");
    property p_unsel;
        i_unit_select_n [*6] |-> o_xfer_hold_n;
    endproperty
    a_unsel: assert property (p_unsel) else $error("hold while deselected");
    property p_done_cause;
        $rose(o_exec_done_n_oe) |-> $past(i_cmd_complete) || $past(i_cmd_complete, 2);
    endproperty
    a_done_cause: assert property (p_done_cause) else $error("done without completion");
    property p_done_ack;
        (!i_done_ack_n && !i_cmd_complete) [*6] |-> !o_exec_done_n_oe;
    endproperty
    a_done_ack: assert property (p_done_ack) else $error("done survives ack");
    property p_att_ack;
        (!i_attention_ack_n && !i_cmd_complete) [*6] |-> !o_host_attention;
    endproperty
    a_att_ack: assert property (p_att_ack) else $error("attention survives ack");
    property p_att_rise;
        $rose(o_host_attention) |-> $rose(o_exec_done_n_oe);
    endproperty
    a_att_rise: assert property (p_att_rise) else $error("attention off completion");
    property p_reset_pin;
        i_reset [*6] |-> !o_busy && o_stack_ptr == 5'h00 && !o_exec_done_n_oe && !o_host_attention;
    endproperty
    a_reset_pin: assert property (p_reset_pin) else $error("reset pin not obeyed");
    property p_pop_index;
        o_pop_req |-> o_pop_index == 5'(o_stack_ptr - 5'h01)
            ##1 o_stack_ptr == $past(o_pop_index);
    endproperty
    a_pop_index: assert property (p_pop_index) else $error("pop index wrong");
    c_done: cover property ($rose(o_exec_done_n_oe));
    c_att: cover property ($rose(o_host_attention));
    c_pop: cover property (o_pop_req);
endmodule
bind apuhb_top apuhb_checker u_apuhb_checker (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst),
    .i_reset(i_reset), .i_unit_select_n(i_unit_select_n), .i_read_strobe_n(i_read_strobe_n),
    .o_host_bus(o_host_bus), .o_host_bus_oe(o_host_bus_oe), .o_xfer_hold_n(o_xfer_hold_n),
    .o_exec_done_n_oe(o_exec_done_n_oe), .o_host_attention(o_host_attention),
    .i_done_ack_n(i_done_ack_n), .i_attention_ack_n(i_attention_ack_n),
    .i_cmd_complete(i_cmd_complete), .o_pop_req(o_pop_req), .o_pop_index(o_pop_index),
    .o_stack_ptr(o_stack_ptr), .o_busy(o_busy));
`default_nettype wire

// File: testbench/apuhb_host_model.sv
// Host processor model driving the select, strobe and bus pins
`default_nettype none
module apuhb_host_model (
    input wire logic i_clk_sys,
    input wire logic i_xfer_hold_n,
    input wire logic [7:0] i_bus_rd,
    output logic o_sel_n,
    output logic o_cd,
    output logic o_rd_n,
    output logic o_wr_n,
    output logic [7:0] o_bus,
    output logic o_timeout
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        o_sel_n = 1'b1;
        o_cd = 1'b0;
        o_rd_n = 1'b1;
        o_wr_n = 1'b1;
        o_bus = 8'h5a;
        o_timeout = 1'b0;
    end
    // One access: strobe held until hold returns high; hold and data looked at mid-cycle
    task automatic xfer(input logic wr, input logic cd, input logic sel_n,
                        input logic [7:0] wdata, output logic [7:0] rdata);
        int n;
        n = 0;
        @(negedge i_clk_sys);
        o_sel_n = sel_n;
        o_cd = cd;
        if (wr) o_bus = wdata;
        o_wr_n = !wr;
        o_rd_n = wr;
        if (sel_n) repeat (8) @(posedge i_clk_sys);
        else begin
            do begin @(negedge i_clk_sys); n++; end while (i_xfer_hold_n !== 1'b0 && n < 40);
            if (n >= 40) o_timeout = 1'b1;
            do begin @(negedge i_clk_sys); n++; end while (i_xfer_hold_n !== 1'b1 && n < 80);
            if (n >= 80) o_timeout = 1'b1;
        end
        rdata = i_bus_rd;
        @(negedge i_clk_sys);
        o_rd_n = 1'b1;
        o_wr_n = 1'b1;
        o_bus = ~o_bus; // Released bus shows no stale value
        @(negedge i_clk_sys);
        o_sel_n = 1'b1;
        repeat (4) @(negedge i_clk_sys);
    endtask
endmodule
`default_nettype wire

// File: testbench/tb.sv
// Self-checking bench for the host bus interface
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, nrst = 1'b0, rst_pin = 1'b1, dack_n = 1'b1, aack_n = 1'b1;
    logic cmp = 1'b0, pready = 1'b1, sel_n, cd, rd_n, wr_n, tmo, oe, hold_n, done, att;
    logic pvalid, preq, cvalid, busy;
    logic [7:0] stat = 8'h25, hbus_in, hbus_out, pdata, popd, d;
    logic [4:0] op, pidx, sp;
    logic [1:0] fmt;
    logic [7:0] mem [0:31];
    int cnt = 0, miscompares = 0, num_checks = 0;
    always #50 clk = ~clk;
    apuhb_host_model u_apuhb_host_model (.i_clk_sys(clk), .i_xfer_hold_n(hold_n),
        .i_bus_rd(hbus_out), .o_sel_n(sel_n), .o_cd(cd), .o_rd_n(rd_n), .o_wr_n(wr_n),
        .o_bus(hbus_in), .o_timeout(tmo));
    apuhb_top u_apuhb_top (.i_clk_sys(clk), .i_nrst(nrst), .i_reset(rst_pin),
        .i_unit_select_n(sel_n), .i_cmd_data_sel(cd), .i_read_strobe_n(rd_n),
        .i_store_strobe_n(wr_n), .i_host_bus(hbus_in), .o_host_bus(hbus_out),
        .o_host_bus_oe(oe), .o_xfer_hold_n(hold_n), .o_exec_done_n_oe(done),
        .o_host_attention(att), .i_done_ack_n(dack_n), .i_attention_ack_n(aack_n),
        .o_cmd_valid(cvalid), .i_cmd_ready(1'b1), .o_cmd_op(op), .o_cmd_fmt(fmt),
        .i_cmd_complete(cmp), .i_status(stat), .o_push_valid(pvalid), .i_push_ready(pready),
        .o_push_data(pdata), .o_pop_req(preq), .o_pop_index(pidx), .i_pop_data(popd),
        .o_stack_ptr(sp), .o_busy(busy));
    ////////////////////////////////////////////////////////////////
    // Engine stack: last byte accepted is returned first
    assign popd = mem[5'(cnt - 1)];
    always @(posedge clk) begin
        if (rst_pin) cnt <= 0;
        else if (pvalid && pready) begin
            mem[5'(cnt)] <= pdata;
            cnt <= cnt + 1;
        end else if (preq) cnt <= cnt - 1;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic c, input logic [7:0] v);
        logic [7:0] x;
        u_apuhb_host_model.xfer(1'b1, c, 1'b0, v, x);
    endtask
    task automatic rd(input logic c, output logic [7:0] v);
        u_apuhb_host_model.xfer(1'b0, c, 1'b0, 8'h00, v);
    endtask
    task automatic finish_cmd;
        @(negedge clk) cmp = 1'b1;
        @(negedge clk) cmp = 1'b0;
        repeat (3) @(negedge clk);
    endtask
    task automatic final_report;
        if (tmo === 1'b1) miscompares++;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        #2000000;
        miscompares++;
        final_report();
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(negedge clk);
        nrst = 1'b1;
        repeat (6) @(negedge clk);
        rst_pin = 1'b0;
        repeat (6) @(negedge clk);
        check({4'h0, hold_n, done, att, oe}, 8'h08);
        $display("test reset done");
        for (int i = 0; i < 4; i++) wr(1'b0, 8'h11 * (i + 1));
        check({3'h0, sp}, 8'h04);
        for (int i = 0; i < 4; i++) check(mem[i], 8'h11 * (i + 1));
        for (int i = 0; i < 4; i++) begin
            rd(1'b0, d);
            check(d, 8'h44 - 8'h11 * i);
        end
        check({3'h0, sp}, 8'h00);
        $display("test push pop done");
        wr(1'b1, 8'hcd);
        check({op, fmt, busy}, {5'h0d, 2'h2, 1'b1});
        check({busy, cvalid}, 8'h03);
        rd(1'b1, d);
        check(d, 8'ha5);
        finish_cmd();
        check({done, att}, 8'h03);
        rd(1'b1, d);
        check(d, 8'h25);
        check({6'h00, done, att}, 8'h01);
        @(negedge clk) aack_n = 1'b0;
        repeat (6) @(negedge clk);
        aack_n = 1'b1;
        check(att, 8'h00);
        $display("test service request done");
        wr(1'b1, 8'h80);
        finish_cmd();
        @(negedge clk) dack_n = 1'b0;
        repeat (6) @(negedge clk);
        dack_n = 1'b1;
        check({done, att}, 8'h01);
        wr(1'b1, 8'h2c);
        finish_cmd();
        check({done, att}, 8'h02);
        wr(1'b1, 8'h6d);
        check(done, 8'h00);
        finish_cmd();
        $display("test completion done");
        u_apuhb_host_model.xfer(1'b1, 1'b0, 1'b1, 8'h99, d);
        check(cnt[7:0], 8'h00);
        $display("test deselect done");
        pready = 1'b0;
        for (int i = 0; i < 8; i++) wr(1'b0, 8'h50 + i);
        fork
            wr(1'b0, 8'h58);
            begin
                repeat (20) @(negedge clk);
                check(hold_n, 8'h00);
                pready = 1'b1;
            end
        join
        repeat (4) @(negedge clk); // Let the last buffered byte drain
        check(cnt[7:0], 8'h09);
        for (int i = 0; i < 9; i++) check(mem[i], 8'h50 + i);
        $display("test buffer done");
        wr(1'b1, 8'h4d);
        @(negedge clk) rst_pin = 1'b1;
        repeat (8) @(negedge clk);
        rst_pin = 1'b0;
        repeat (6) @(negedge clk);
        check({busy, op, fmt}, {1'b0, 5'h0d, 2'h2});
        check({3'h0, sp}, 8'h00);
        $display("test reset pin done");
        final_report();
    end
endmodule
`default_nettype wire
